// file: src/dual_port_pkg.sv
// Constants shared by the dual port pin logic
package dual_port_pkg;
    localparam int          PORT_WIDTH      = 8;
    localparam logic [7:0]  LATCH_RESET     = 8'hff;
    localparam int          COUNT_PIN_BIT   = 0;
    localparam int          TRIGGER_PIN_BIT = 1;
    // Bus phase: one-hot
    typedef enum logic [2:0]
    {
        PHASE_IDLE = 3'b001,
        PHASE_ADDR = 3'b010,
        PHASE_DATA = 3'b100
    } bus_phase_type;
endpackage

// file: src/dual_io_port_pins.sv
// Pin logic of the open-drain bus port and the pullup port
// Contract
// - First port: eight open-drain pins, pulling low only when latch zero
// - Writing one to a first-port pin releases it to float as input
// - External accesses multiplex low address then data on the first port
// - As external bus, first port uses internal pullups, not open drain
// - Programming takes code bytes from first port; verify drives them out
// - Second port: eight pins with internal pullups, low when latch zero
// - Writing one to second-port pin lets pullup hold it high as input
// - Second-port bit 0 is timer two count input and clock-out output
// - Second-port bit 1 is timer two capture/reload trigger and direction
// - In programming and verify, second port carries low byte address; the code captures it and releases the pins in programming only
`timescale 1ns/10ps
module dual_io_port_pins
    import dual_port_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Core latch writes
    input  wire logic             bus_latch_we,
    input  wire logic [WIDTH-1:0] bus_latch_wdata,
    input  wire logic             pullup_latch_we,
    input  wire logic [WIDTH-1:0] pullup_latch_wdata,
    // External bus request from core
    input  wire logic             ext_addr_phase,
    input  wire logic             ext_data_phase,
    input  wire logic             ext_write,
    input  wire logic [WIDTH-1:0] ext_addr_low,
    input  wire logic [WIDTH-1:0] ext_wdata,
    // Programming mode and stored code byte
    input  wire logic             prog_mode,
    input  wire logic             verify_mode,
    input  wire logic [WIDTH-1:0] verify_code,
    // Timer two alternate functions
    input  wire logic             clock_out_en,
    input  wire logic             clock_out_level,
    // First port pin
    input  wire logic [WIDTH-1:0] open_drain_bus_port_in,
    output logic      [WIDTH-1:0] open_drain_bus_port_out,
    output logic      [WIDTH-1:0] open_drain_bus_port_oe_n,
    // Second port pin, plus the first-port pullup enable
    input  wire logic [WIDTH-1:0] pullup_port_one_in,
    output logic      [WIDTH-1:0] pullup_port_one_out,
    output logic      [WIDTH-1:0] pullup_port_one_oe_n,
    output logic      [WIDTH-1:0] pullup_port_one_pullup_en,
    output logic      [WIDTH-1:0] open_drain_bus_port_pullup_en,
    // Core side read-back
    output logic      [WIDTH-1:0] bus_pin_rdata,
    output logic      [WIDTH-1:0] pullup_pin_rdata,
    output logic      [WIDTH-1:0] ext_rdata,
    output logic      [WIDTH-1:0] prog_code,
    output logic      [WIDTH-1:0] prog_addr_low,
    output logic                  timer_two_count_input,
    output logic                  timer_two_trigger_input,
    output logic                  bus_phase_addr
);
    // ------------------------------------------------------------
    // Latches and phase
    // ------------------------------------------------------------
    logic [WIDTH-1:0] bus_latch;
    logic [WIDTH-1:0] pullup_latch;
    bus_phase_type    phase;
    bus_phase_type    next_phase;
    wire              ext_active = ext_addr_phase | ext_data_phase;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bus_latch    <= LATCH_RESET[WIDTH-1:0];
            pullup_latch <= LATCH_RESET[WIDTH-1:0];
            phase        <= PHASE_IDLE;
        end
        else
        begin
            if (bus_latch_we)
                bus_latch <= bus_latch_wdata;
            if (pullup_latch_we)
                pullup_latch <= pullup_latch_wdata;
            phase <= next_phase;
        end
    end

    // Address before data within an access
    always_comb
    begin
        case (phase)
            PHASE_IDLE: next_phase = ext_addr_phase ? PHASE_ADDR : PHASE_IDLE;
            PHASE_ADDR: next_phase = ext_data_phase ? PHASE_DATA
                                   : (ext_addr_phase ? PHASE_ADDR
                                                     : PHASE_IDLE);
            PHASE_DATA: next_phase = ext_data_phase ? PHASE_DATA
                                   : (ext_addr_phase ? PHASE_ADDR
                                                     : PHASE_IDLE);
            default:    next_phase = PHASE_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Drive decode
    // ------------------------------------------------------------
    // Bus drives both levels; latch and verify only pull low
    wire drive_addr = ext_addr_phase;
    wire drive_wr   = ext_data_phase & ext_write;
    wire [WIDTH-1:0] bus_value = drive_addr ? ext_addr_low : ext_wdata;
    wire [WIDTH-1:0] od_source =
        verify_mode ? verify_code : bus_latch;
    wire [WIDTH-1:0] next_bus_oe_n =
        (drive_addr | drive_wr) ? {WIDTH{1'b0}}
        : (prog_mode ? {WIDTH{1'b1}}
        : (ext_active ? {WIDTH{1'b1}} : od_source));
    wire [WIDTH-1:0] next_bus_out =
        (drive_addr | drive_wr) ? bus_value : {WIDTH{1'b0}};

    wire [WIDTH-1:0] pullup_src;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : gen_pullup_src
            if (g == COUNT_PIN_BIT)
                assign pullup_src[g] = clock_out_en
                    ? (pullup_latch[g] & clock_out_level)
                    : pullup_latch[g];
            else
                assign pullup_src[g] = pullup_latch[g];
        end
    endgenerate
    // Pins drive only low; the pullup holds ones
    wire [WIDTH-1:0] next_pull_oe_n =
        prog_mode ? {WIDTH{1'b1}} : pullup_src;

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            open_drain_bus_port_out       <= '0;
            open_drain_bus_port_oe_n      <= '1;
            open_drain_bus_port_pullup_en <= '0;
            pullup_port_one_out           <= '0;
            pullup_port_one_oe_n          <= '1;
            pullup_port_one_pullup_en     <= '1;
            bus_pin_rdata                 <= '0;
            pullup_pin_rdata              <= '0;
            ext_rdata                     <= '0;
            prog_code                     <= '0;
            prog_addr_low                 <= '0;
            timer_two_count_input         <= 1'b0;
            timer_two_trigger_input       <= 1'b0;
            bus_phase_addr                <= 1'b0;
        end
        else
        begin
            open_drain_bus_port_out       <= next_bus_out;
            open_drain_bus_port_oe_n      <= next_bus_oe_n;
            open_drain_bus_port_pullup_en <= {WIDTH{ext_active}};
            pullup_port_one_out           <= '0;
            pullup_port_one_oe_n          <= next_pull_oe_n;
            pullup_port_one_pullup_en     <= '1;
            bus_pin_rdata                 <= open_drain_bus_port_in;
            pullup_pin_rdata              <= pullup_port_one_in;
            if (ext_data_phase && !ext_write)
                ext_rdata <= open_drain_bus_port_in;
            if (prog_mode)
            begin
                prog_code     <= open_drain_bus_port_in;
                prog_addr_low <= pullup_port_one_in;
            end
            timer_two_count_input   <=
                pullup_port_one_in[COUNT_PIN_BIT];
            timer_two_trigger_input <=
                pullup_port_one_in[TRIGGER_PIN_BIT];
            bus_phase_addr          <= (next_phase == PHASE_ADDR);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking check_clk @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Address byte, then a write byte with no address overlap
    sequence s_addr_then_write;
        ext_addr_phase ##1 (ext_data_phase && ext_write && !ext_addr_phase);
    endsequence

    a_reset_latch_ones: assert property (
        $rose(reset_n) |-> (bus_latch == '1 && pullup_latch == '1))
        else $error("latches not all ones after reset");
    a_od_low_only: assert property (
        !$past(ext_active) |-> open_drain_bus_port_out == '0)
        else $error("open drain port drove high");
    a_od_release: assert property (
        (!ext_active && !prog_mode && !verify_mode && bus_latch == '1)
        |=> open_drain_bus_port_oe_n == '1)
        else $error("open drain pin not released");
    a_addr_drive: assert property (
        ext_addr_phase |=> (open_drain_bus_port_oe_n == '0
            && open_drain_bus_port_out == $past(ext_addr_low)))
        else $error("address byte not driven");
    a_data_drive: assert property (
        s_addr_then_write |=> (open_drain_bus_port_oe_n == '0
            && open_drain_bus_port_out == $past(ext_wdata)))
        else $error("write byte not driven after address");
    a_bus_pullup: assert property (
        ext_active |=> open_drain_bus_port_pullup_en == '1)
        else $error("bus pullups off during access");
    a_verify_out: assert property (
        (verify_mode && !prog_mode && !ext_active)
        |=> open_drain_bus_port_oe_n == $past(verify_code))
        else $error("verify code byte not driven");
    a_pull_low: assert property (
        (!prog_mode && !clock_out_en)
        |=> pullup_port_one_oe_n == $past(pullup_latch))
        else $error("second port not following latch");
    a_pull_release: assert property (
        !prog_mode |=> (pullup_port_one_pullup_en == '1
            && pullup_port_one_out == '0))
        else $error("second port pullup not holding released pins");
    a_clock_out: assert property (
        (clock_out_en && !clock_out_level && !prog_mode)
        |=> !pullup_port_one_oe_n[COUNT_PIN_BIT])
        else $error("clock-out low not driven on count pin");
    a_count_in: assert property (
        1'b1 |=> timer_two_count_input
            == $past(pullup_port_one_in[COUNT_PIN_BIT]))
        else $error("count input not forwarded");
    a_prog_addr: assert property (
        prog_mode |=> (prog_addr_low == $past(pullup_port_one_in)
            && pullup_port_one_oe_n == '1))
        else $error("programming address not captured");
    a_trig_in: assert property (
        1'b1 |=> timer_two_trigger_input
            == $past(pullup_port_one_in[TRIGGER_PIN_BIT]))
        else $error("trigger input not forwarded");
endmodule

// file: test/pin_partner.sv
// Far-side pin model: external memory, peripherals or programmer
`timescale 1ns/10ps
module pin_partner
(
    // Clock
    input  wire logic       clk,
    // Device drive of both ports
    input  wire logic [7:0] od_out,
    input  wire logic [7:0] od_oe_n,
    input  wire logic [7:0] od_pu,
    input  wire logic [7:0] pu_out,
    input  wire logic [7:0] pu_oe_n,
    input  wire logic [7:0] pu_pu,
    // Far-side drive and programmer pullups
    input  wire logic [7:0] far_od,
    input  wire logic [7:0] far_od_en,
    input  wire logic [7:0] far_pu,
    input  wire logic [7:0] far_pu_en,
    input  wire logic       prog_pull,
    // Resolved pin levels
    output logic      [7:0] od_pin,
    output logic      [7:0] pu_pin
);
    logic [7:0] noise = 8'h5a;
    // Unpulled released lines toggle so a stale level never passes
    always @(posedge clk) noise <= ~noise;
    function automatic logic [7:0] level(input logic [7:0] oe_n, out, en,
                                         val, pull, nz);
        return ~oe_n & out | oe_n & en & val | oe_n & ~en & pull
               | oe_n & ~en & ~pull & nz;
    endfunction
    // Code bytes and address from programmer, pullups in verify
    assign od_pin = level(od_oe_n, od_out, far_od_en, far_od,
                          od_pu | {8{prog_pull}}, noise);
    assign pu_pin = level(pu_oe_n, pu_out, far_pu_en, far_pu, pu_pu,
                          noise);
endmodule

// file: test/tb.sv
// Self-checking bench for the dual port pin logic
`timescale 1ns/10ps
module tb;
    import dual_port_pkg::*;
    logic        clk = 1'b0, reset_n = 1'b0, blw = 1'b0, plw = 1'b0;
    logic        ap = 1'b0, dp = 1'b0, wr = 1'b0, pm = 1'b0, vm = 1'b0;
    logic        coe = 1'b0, clv = 1'b0, pull = 1'b0;
    logic  [7:0] bd = 8'h00, pd = 8'h00, ad = 8'h00, wd = 8'h00;
    logic  [7:0] vc = 8'h00, fo = 8'h00, foe = 8'h00, fp = 8'h00;
    logic  [7:0] fpe = 8'h00;
    wire   [7:0] od_in, od_out, od_oe_n, od_pu, pu_in, pu_out, pu_oe_n;
    wire   [7:0] pu_pu, bus_rd, pu_rd, ext_rd, p_code, p_addr;
    wire         t_cnt, t_trg, ph_a;
    logic [31:0] seed = 32'h8f38a9af;
    logic [11:0] q[$];
    logic [11:0] e;
    int          fails = 0, n_tests = 0;
    event        smp;
    always #12.5 clk = ~clk;
    dual_io_port_pins #(.WIDTH(PORT_WIDTH)) dual_io_port_pins_inst
    (.clk(clk), .reset_n(reset_n), .bus_latch_we(blw),
     .bus_latch_wdata(bd), .pullup_latch_we(plw), .pullup_latch_wdata(pd),
     .ext_addr_phase(ap), .ext_data_phase(dp), .ext_write(wr),
     .ext_addr_low(ad), .ext_wdata(wd), .prog_mode(pm), .verify_mode(vm),
     .verify_code(vc), .clock_out_en(coe), .clock_out_level(clv),
     .open_drain_bus_port_in(od_in), .open_drain_bus_port_out(od_out),
     .open_drain_bus_port_oe_n(od_oe_n), .pullup_port_one_in(pu_in),
     .pullup_port_one_out(pu_out), .pullup_port_one_oe_n(pu_oe_n),
     .pullup_port_one_pullup_en(pu_pu), .open_drain_bus_port_pullup_en(od_pu),
     .bus_pin_rdata(bus_rd), .pullup_pin_rdata(pu_rd), .ext_rdata(ext_rd),
     .prog_code(p_code), .prog_addr_low(p_addr),
     .timer_two_count_input(t_cnt), .timer_two_trigger_input(t_trg),
     .bus_phase_addr(ph_a));
    pin_partner pin_partner_inst
    (.clk(clk), .od_out(od_out), .od_oe_n(od_oe_n), .od_pu(od_pu),
     .pu_out(pu_out), .pu_oe_n(pu_oe_n), .pu_pu(pu_pu), .far_od(fo),
     .far_od_en(foe), .far_pu(fp), .far_pu_en(fpe), .prog_pull(pull),
     .od_pin(od_in), .pu_pin(pu_in));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] got(input logic [3:0] s);
        case (s)
            4'h0: return od_oe_n;
            4'h1: return od_out;
            4'h2: return od_pu;
            4'h3: return pu_oe_n;
            4'h4: return ext_rd;
            4'h5: return p_code;
            4'h6: return p_addr;
            4'h7: return bus_rd;
            4'h8: return pu_rd;
            4'h9: return {6'h00, t_trg, t_cnt};
            4'hb: return {7'h00, ph_a};
            4'hc: return pu_out;
            default: return pu_pu;
        endcase
    endfunction
    task automatic want(input int s, input logic [7:0] v);
        q.push_back({s[3:0], v});
    endtask
    // Outputs lag inputs by a clock; three cycles leaves margin
    task automatic settle();
        repeat (3) @(negedge clk);
        ->smp;
        // Next stimulus only once the checker has drained its notes
        wait (q.size() == 0);
    endtask
    task automatic wlatch(input logic [7:0] b, input logic [7:0] p);
        {bd, pd, blw, plw} = {b, p, 2'b11};
        @(negedge clk);
        {blw, plw} = 2'b00;
    endtask
    always @(smp)
    begin
        while (q.size() > 0)
        begin
            e = q.pop_front();
            n_tests++;
            if (got(e[11:8]) !== e[7:0])
            begin
                fails++;
                $display("wrong value at %0t: got %h expected %h", $time,
                         got(e[11:8]), e[7:0]);
            end
        end
    end
    task automatic close_out();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #(4000 * 25);
        fails++;
        close_out();
    end
    initial
    begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        want(0, 8'hff);
        want(3, 8'hff);
        want(10, 8'hff);
        want(2, 8'h00);
        want(12, 8'h00);
        settle();
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(lfsr(seed));
            {fo, fp, fpe} = seed[23:0];
            foe = 8'hff;
            wlatch(seed[31:24], seed[15:8] ^ seed[31:24]);
            want(0, bd);
            want(2, 8'h00);
            want(7, bd & fo);
            want(3, pd);
            want(8, pd & (~fpe | fp));
            want(9, {6'h00, pd[1:0] & (~fpe[1:0] | fp[1:0])});
            settle();
        end
        wlatch(8'hff, 8'hff);
        {coe, clv} = 2'b10;
        want(3, 8'hfe);
        settle();
        clv = 1'b1;
        want(3, 8'hff);
        settle();
        {coe, ap, ad, foe} = {2'b01, seed[7:0], 8'h00};
        want(0, 8'h00);
        want(1, ad);
        want(2, 8'hff);
        want(11, 8'h01);
        settle();
        {ap, dp, wr, wd} = {3'b011, seed[15:8]};
        want(1, wd);
        want(11, 8'h00);
        want(0, 8'h00);
        settle();
        {wr, foe, fo} = {1'b0, 8'hff, seed[23:16]};
        want(4, fo);
        want(0, 8'hff);
        want(2, 8'hff);
        settle();
        dp = 1'b0;
        wlatch(8'h00, 8'h00);
        {pm, fp, fpe} = {1'b1, seed[31:24], 8'hff};
        want(5, fo);
        want(6, fp);
        want(0, 8'hff);
        want(3, 8'hff);
        settle();
        {pm, vm, vc, foe, fpe, pull} = {2'b01, seed[11:4], 16'h0000, 1'b1};
        want(0, vc);
        want(7, vc);
        settle();
        {vm, pull} = 2'b00;
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        want(0, 8'hff);
        want(3, 8'hff);
        settle();
        close_out();
    end
endmodule
